// >>> logic/acc_pkg.sv
/*
 * Shared constants and types of the converter control and calibration block.
 * Assumes a 20 MHz modulator clock and a byte-wide register port from the
 * serial interface logic.
 */
// Behaviour
// - each conversion start waits a programmable delay; code 0001 means 50 us
// - auto-zero flips input polarity each half and subtracts the pair
// - auto-zero acts only when the a/b input pair is selected
// - with auto-zero, results come once per normal latency
// - with auto-zero, first result after start takes twice the latency
// - toggling external clock is detected and selected, else internal oscillator
// - status bit shows whether the external clock is in use
// - every reset returns control logic and registers to defaults
// - every reset sets a status flag that software clears
// - start input high at end of reset begins conversions at once
// - after power-on, ready output stays low for 2^16 cycles, then high
// - first conversion begins 512 cycles after ready goes high
// - reset pin low at least four cycles; conversion 512 cycles after release
// - host raises select before reset command; conversion 512 cycles later
// - output is (raw minus offset) times gain over 400000h, clipped to 24 bits
// - offset word bytes sit at 07h, 08h and 09h, low to high
// - offset word is two's complement; zero applies no correction
// - gain word bytes sit at 0Ah, 0Bh and 0Ch, low to high
// - gain word is unsigned with unity at 400000h
// - calibration words may be written directly by the host
// - ready goes high when a conversion starts, low when data are ready
package acc_pkg;
	localparam logic [7:0]  ADDR_STATE   = 8'h01;
	localparam logic [7:0]  ADDR_CONFIG  = 8'h02;
	localparam logic [7:0]  ADDR_OFS0    = 8'h07;
	localparam logic [7:0]  ADDR_OFS1    = 8'h08;
	localparam logic [7:0]  ADDR_OFS2    = 8'h09;
	localparam logic [7:0]  ADDR_GAIN0   = 8'h0A;
	localparam logic [7:0]  ADDR_GAIN1   = 8'h0B;
	localparam logic [7:0]  ADDR_GAIN2   = 8'h0C;
	localparam int          CFG_AZ_BIT   = 0;
	localparam int          CFG_PAIR_BIT = 1;
	localparam int          CFG_DLY_LSB  = 4;
	localparam int          ST_FLAG_BIT  = 0;
	localparam int          ST_CLK_BIT   = 1;
	localparam int          ST_BUSY_BIT  = 2;
	localparam logic [7:0]  CONFIG_RST   = 8'h12;
	localparam logic [23:0] OFS_RST      = 24'h000000;
	localparam logic [23:0] GAIN_RST     = 24'h400000;
	localparam int          GAIN_SHIFT   = 22;
	localparam int          CLK_NS       = 50;
	localparam int          DLY_UNIT_NS  = 50000;
	localparam int          DLY_UNIT_CYC = (DLY_UNIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int          POR_CYC      = 65536;
	localparam int          START_CYC    = 512;
	localparam int          PIN_RST_CYC  = 4;
	localparam int          EXT_LOSS_CYC = 64;
	localparam int          FILT_CYC     = 1000000;
	typedef enum logic [2:0] {
		PH_POR   = 3'b000,
		PH_WAIT  = 3'b001,
		PH_IDLE  = 3'b010,
		PH_DELAY = 3'b011,
		PH_RUN   = 3'b100
	} acc_phase_t;
	typedef struct packed {
		logic [23:0] raw;
		logic [23:0] ofs;
		logic [23:0] gain;
	} acc_cal_in_t;
endpackage

// >>> logic/acc_cal.sv
/*
 * Calibration stage: subtracts the offset word, scales by the gain word and
 * clips to 24 bits. One register stage with valid/ready on both sides.
 */
`timescale 1ns/100ps
module acc_cal (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               in_valid,
	input  wire acc_pkg::acc_cal_in_t in_data,
	output logic                    in_ready,
	output logic                    out_valid,
	output logic [23:0]             out_data,
	input  wire logic               out_ready
);
	typedef struct packed {
		logic        v;
		logic [23:0] d;
	} acc_cal_st_t;

	acc_cal_st_t s, next_s;
	logic signed [24:0] diff;
	logic signed [49:0] prod;
	logic signed [27:0] scaled;

	assign in_ready  = !s.v || out_ready;
	assign out_valid = s.v;
	assign out_data  = s.d;

	always_comb begin
		next_s = s;
		diff   = $signed({in_data.raw[23], in_data.raw})
			- $signed({in_data.ofs[23], in_data.ofs});
		prod   = diff * $signed({1'b0, in_data.gain});
		scaled = prod[49:acc_pkg::GAIN_SHIFT];
		if (out_ready) begin
			next_s.v = 1'b0;
		end
		if (in_valid && in_ready) begin
			next_s.v = 1'b1;
			if (scaled[27:23] == {5{scaled[23]}}) begin
				next_s.d = scaled[23:0];
			end else if (scaled[27]) begin
				next_s.d = 24'h800000;
			end else begin
				next_s.d = 24'h7FFFFF;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	unity_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
		(in_valid && in_ready && in_data.gain == 24'h400000 && in_data.ofs == 24'h000000)
		|=> (out_valid && out_data == $past(in_data.raw)))
		else $error("unity gain and zero offset changed the result");
endmodule

// >>> logic/acc_fifo.sv
/*
 * Result buffer: first in, first out, width and depth set by parameters.
 * Assumes one clock; the reader may stall and the writer sees full.
 */
`timescale 1ns/100ps
module acc_fifo #(
	parameter int W = 24,
	parameter int D = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} acc_fifo_st_t;

	acc_fifo_st_t s, next_s;
	logic [W-1:0] mem [D];
	logic         do_wr;
	logic         do_rd;

	assign in_ready  = s.cnt != (AW+1)'(D);
	assign out_valid = s.cnt != '0;
	assign out_data  = mem[s.rp];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	always_comb begin
		next_s = s;
		if (do_wr) begin
			next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
		end
		if (do_rd) begin
			next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
		end
		if (do_wr && !do_rd) begin
			next_s.cnt = s.cnt + 1'b1;
		end else if (do_rd && !do_wr) begin
			next_s.cnt = s.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[s.wp] <= in_data;
		end
	end
endmodule

// >>> logic/acc_ctrl.sv
/*
 * Conversion control: start-up and reset timing, start delay, auto-zero
 * sequencing, clock detection, status and calibration registers.
 * Assumes raw results from the digital filter on the same clock and a
 * byte register port driven by the serial interface logic.
 */
`timescale 1ns/100ps
module acc_ctrl #(
	parameter int POR_CYC  = acc_pkg::POR_CYC,
	parameter int FILT_CYC = acc_pkg::FILT_CYC,
	parameter int FIFO_D   = 32
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        reset_pin_n,
	input  wire logic        reset_cmd,
	input  wire logic        start_pin,
	input  wire logic        external_clock_input,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rd_data,
	input  wire logic [23:0] raw_data,
	output logic             sample_ready_n,
	output logic             filter_run,
	output logic             chop_invert,
	output logic             clk_sel_ext,
	output logic             out_valid,
	output logic [23:0]      out_data,
	input  wire logic        out_ready
);
	typedef struct packed {
		acc_pkg::acc_phase_t phase;
		logic [19:0]         cnt;
		logic                sr_n;
		logic                run;
		logic                flag;
		logic [7:0]          cfg;
		logic [23:0]         ofs;
		logic [23:0]         gain;
		logic [7:0]          rd;
		logic [2:0]          st_s;
		logic [1:0]          rp_s;
		logic [2:0]          lo_cnt;
		logic                armed;
		logic [2:0]          ex_s;
		logic [6:0]          ex_idle;
		logic                ext;
		logic                pol;
		logic                az_first;
		logic                cont;
		logic [23:0]         az_prev;
		logic                cal_v;
		acc_pkg::acc_cal_in_t cal_d;
	} acc_ctrl_st_t;

	localparam acc_ctrl_st_t INIT = '{
		phase: acc_pkg::PH_POR, cnt: '0, sr_n: 1'b0, run: 1'b0, flag: 1'b1,
		cfg: acc_pkg::CONFIG_RST, ofs: acc_pkg::OFS_RST, gain: acc_pkg::GAIN_RST,
		rd: '0, st_s: '0, rp_s: 2'h3, lo_cnt: '0, armed: 1'b0, ex_s: '0,
		ex_idle: 7'h7F, ext: 1'b0, pol: 1'b0, az_first: 1'b0, cont: 1'b0,
		az_prev: '0, cal_v: 1'b0, cal_d: '0};

	acc_ctrl_st_t s, next_s;
	logic         cal_in_ready;
	logic         cal_out_valid;
	logic [23:0]  cal_out_data;
	logic         fifo_in_ready;
	logic [19:0]  dly_cyc;
	logic         start_lvl;
	logic         start_rise;
	logic         soft_rst;
	logic         ex_edge;
	logic signed [24:0] az_diff;

	function automatic logic az_active(input logic [7:0] cfg);
		return cfg[acc_pkg::CFG_AZ_BIT] && cfg[acc_pkg::CFG_PAIR_BIT];
	endfunction

	assign start_lvl  = s.st_s[1];
	assign start_rise = s.st_s[1] && !s.st_s[2];
	assign ex_edge    = s.ex_s[1] ^ s.ex_s[2];

	always_comb begin
		next_s  = s;
		dly_cyc = 20'(s.cfg[7:acc_pkg::CFG_DLY_LSB]) * 20'(acc_pkg::DLY_UNIT_CYC);
		az_diff = '0;
		soft_rst = 1'b0;
		next_s.st_s = {s.st_s[1:0], start_pin};
		next_s.rp_s = {s.rp_s[0], reset_pin_n};
		next_s.ex_s = {s.ex_s[1:0], external_clock_input};

		// external clock presence watch
		if (ex_edge) begin
			next_s.ex_idle = '0;
		end else if (s.ex_idle != 7'h7F) begin
			next_s.ex_idle = s.ex_idle + 1'b1;
		end
		next_s.ext = s.ex_idle < 7'(acc_pkg::EXT_LOSS_CYC);

		// reset pin must stay low a minimum time before it counts
		if (!s.rp_s[1]) begin
			if (s.lo_cnt != 3'(acc_pkg::PIN_RST_CYC)) begin
				next_s.lo_cnt = s.lo_cnt + 1'b1;
			end
			next_s.armed = (s.lo_cnt >= 3'(acc_pkg::PIN_RST_CYC - 1));
		end else begin
			next_s.lo_cnt = '0;
			next_s.armed  = 1'b0;
			soft_rst      = s.armed;
		end
		if (reset_cmd) begin
			soft_rst = 1'b1;
		end

		if (s.cal_v && cal_in_ready) begin
			next_s.cal_v = 1'b0;
		end

		case (s.phase)
			acc_pkg::PH_POR: begin
				next_s.sr_n = 1'b0;
				next_s.cnt  = s.cnt + 1'b1;
				if (s.cnt == 20'(POR_CYC - 1)) begin
					next_s.sr_n  = 1'b1;
					next_s.cnt   = '0;
					next_s.phase = acc_pkg::PH_WAIT;
				end
			end
			acc_pkg::PH_WAIT: begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == 20'(acc_pkg::START_CYC - 1)) begin
					next_s.cnt   = '0;
					next_s.phase = acc_pkg::PH_IDLE;
					if (start_lvl) begin
						next_s.phase    = acc_pkg::PH_DELAY;
						next_s.sr_n     = 1'b1;
						next_s.pol      = 1'b0;
						next_s.az_first = az_active(s.cfg);
					end
				end
			end
			acc_pkg::PH_IDLE: begin
				if (start_lvl) begin
					next_s.phase    = acc_pkg::PH_DELAY;
					next_s.cnt      = '0;
					next_s.sr_n     = 1'b1;
					next_s.az_first = az_active(s.cfg) && !(s.cont && !start_rise);
					if (!s.cont || start_rise) begin
						next_s.pol = 1'b0;
					end
				end
			end
			acc_pkg::PH_DELAY: begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt + 20'h00001 >= dly_cyc) begin
					next_s.cnt   = '0;
					next_s.phase = acc_pkg::PH_RUN;
					next_s.run   = 1'b1;
				end
			end
			acc_pkg::PH_RUN: begin
				if (s.cnt != 20'(FILT_CYC - 1)) begin
					next_s.cnt = s.cnt + 1'b1;
				end else if (!s.cal_v) begin
					next_s.run     = 1'b0;
					next_s.cnt     = '0;
					next_s.az_prev = raw_data;
					next_s.pol     = !s.pol;
					if (az_active(s.cfg) && s.az_first) begin
						next_s.az_first = 1'b0;
						next_s.phase    = acc_pkg::PH_DELAY;
					end else begin
						if (az_active(s.cfg)) begin
							az_diff = s.pol
								? $signed({s.az_prev[23], s.az_prev}) - $signed({raw_data[23], raw_data})
								: $signed({raw_data[23], raw_data}) - $signed({s.az_prev[23], s.az_prev});
							next_s.cal_d.raw = az_diff[24:1];
						end else begin
							next_s.cal_d.raw = raw_data;
							next_s.pol       = 1'b0;
						end
						next_s.cal_d.ofs  = s.ofs;
						next_s.cal_d.gain = s.gain;
						next_s.cal_v      = 1'b1;
						next_s.sr_n       = 1'b0;
						next_s.cont       = start_lvl;
						next_s.phase      = acc_pkg::PH_IDLE;
					end
				end
			end
			default: begin
				next_s.phase = acc_pkg::PH_IDLE;
			end
		endcase

		// a fresh start edge restarts a conversion in progress
		if (start_rise && (s.phase == acc_pkg::PH_DELAY || s.phase == acc_pkg::PH_RUN)) begin
			next_s.phase    = acc_pkg::PH_DELAY;
			next_s.cnt      = '0;
			next_s.run      = 1'b0;
			next_s.sr_n     = 1'b1;
			next_s.pol      = 1'b0;
			next_s.az_first = az_active(s.cfg);
		end

		// register port
		if (reg_wr) begin
			if (reg_addr == acc_pkg::ADDR_STATE) begin
				if (reg_wdata[acc_pkg::ST_FLAG_BIT]) begin
					next_s.flag = 1'b0;
				end
			end else if (reg_addr == acc_pkg::ADDR_CONFIG) begin
				next_s.cfg = reg_wdata;
			end else if (reg_addr == acc_pkg::ADDR_OFS0) begin
				next_s.ofs[7:0] = reg_wdata;
			end else if (reg_addr == acc_pkg::ADDR_OFS1) begin
				next_s.ofs[15:8] = reg_wdata;
			end else if (reg_addr == acc_pkg::ADDR_OFS2) begin
				next_s.ofs[23:16] = reg_wdata;
			end else if (reg_addr == acc_pkg::ADDR_GAIN0) begin
				next_s.gain[7:0] = reg_wdata;
			end else if (reg_addr == acc_pkg::ADDR_GAIN1) begin
				next_s.gain[15:8] = reg_wdata;
			end else if (reg_addr == acc_pkg::ADDR_GAIN2) begin
				next_s.gain[23:16] = reg_wdata;
			end
		end
		if (reg_addr == acc_pkg::ADDR_STATE) begin
			next_s.rd = 8'h00;
			next_s.rd[acc_pkg::ST_FLAG_BIT] = s.flag;
			next_s.rd[acc_pkg::ST_CLK_BIT]  = s.ext;
			next_s.rd[acc_pkg::ST_BUSY_BIT] = s.phase == acc_pkg::PH_DELAY
				|| s.phase == acc_pkg::PH_RUN;
		end else if (reg_addr == acc_pkg::ADDR_CONFIG) begin
			next_s.rd = s.cfg;
		end else if (reg_addr == acc_pkg::ADDR_OFS0) begin
			next_s.rd = s.ofs[7:0];
		end else if (reg_addr == acc_pkg::ADDR_OFS1) begin
			next_s.rd = s.ofs[15:8];
		end else if (reg_addr == acc_pkg::ADDR_OFS2) begin
			next_s.rd = s.ofs[23:16];
		end else if (reg_addr == acc_pkg::ADDR_GAIN0) begin
			next_s.rd = s.gain[7:0];
		end else if (reg_addr == acc_pkg::ADDR_GAIN1) begin
			next_s.rd = s.gain[15:8];
		end else if (reg_addr == acc_pkg::ADDR_GAIN2) begin
			next_s.rd = s.gain[23:16];
		end else begin
			next_s.rd = 8'h00;
		end

		// pin or command reset: own state to defaults except wait phase and ready high, synchronisers kept; cal stage and buffer keep theirs
		if (soft_rst) begin
			next_s       = INIT;
			next_s.st_s  = s.st_s;
			next_s.rp_s  = s.rp_s;
			next_s.ex_s  = s.ex_s;
			next_s.phase = acc_pkg::PH_WAIT;
			next_s.sr_n  = 1'b1;
			next_s.flag  = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= INIT;
		end else begin
			s <= next_s;
		end
	end

	assign sample_ready_n = s.sr_n;
	assign filter_run     = s.run;
	assign chop_invert    = s.pol;
	assign clk_sel_ext    = s.ext;
	assign reg_rd_data    = s.rd;

	acc_cal u_cal (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (s.cal_v),
		.in_data   (s.cal_d),
		.in_ready  (cal_in_ready),
		.out_valid (cal_out_valid),
		.out_data  (cal_out_data),
		.out_ready (fifo_in_ready)
	);

	acc_fifo #(
		.W (24),
		.D (FIFO_D)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (cal_out_valid),
		.in_data   (cal_out_data),
		.in_ready  (fifo_in_ready),
		.out_valid (out_valid),
		.out_data  (out_data),
		.out_ready (out_ready)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence conv_begin;
		(s.phase == acc_pkg::PH_IDLE || s.phase == acc_pkg::PH_WAIT)
		##1 s.phase == acc_pkg::PH_DELAY;
	endsequence

	sequence az_half_end;
		s.phase == acc_pkg::PH_RUN ##1 s.phase == acc_pkg::PH_DELAY && !$past(start_rise);
	endsequence

	por_hold_a: assert property (
		(s.phase == acc_pkg::PH_POR && !$rose(s.sr_n)) |-> !sample_ready_n)
		else $error("ready output left low hold early");
	por_release_a: assert property (
		$rose(sample_ready_n) && $past(s.phase) == acc_pkg::PH_POR
		|-> $past(s.cnt) == 20'(POR_CYC - 1))
		else $error("ready output rose at the wrong count");
	wait_len_a: assert property (
		(s.phase == acc_pkg::PH_WAIT && s.cnt < 20'(acc_pkg::START_CYC - 1)
		&& !reset_cmd && !s.armed) |=> s.phase == acc_pkg::PH_WAIT)
		else $error("start wait ended early");
	cmd_reset_a: assert property (
		reset_cmd |=> (s.phase == acc_pkg::PH_WAIT && s.cnt == '0 && s.flag))
		else $error("reset command did not restart timing");
	flag_keep_a: assert property (
		(s.flag && !(reg_wr && reg_addr == acc_pkg::ADDR_STATE
		&& reg_wdata[acc_pkg::ST_FLAG_BIT])) |=> s.flag)
		else $error("reset flag lost without a clear");
	start_high_a: assert property (
		conv_begin |-> sample_ready_n)
		else $error("ready output not high at conversion start");
	chop_flip_a: assert property (
		az_half_end |-> s.pol != $past(s.pol))
		else $error("polarity not reversed between halves");
	az_first_a: assert property (
		(az_half_end ##0 $past(s.az_first)) |-> !s.cal_v)
		else $error("result given after a single half");
	ext_sel_a: assert property (
		(ex_edge && !soft_rst) ##1 !soft_rst |=> clk_sel_ext)
		else $error("toggling clock not selected");
endmodule

// >>> test/acc_filter_model.sv
/*
 * Far-side model: digital filter raw results and an external clock source.
 * Assumes the raw word is sampled on the last cycle of filter_run.
 */
`timescale 1ns/100ps
module acc_filter_model (
	input  wire logic        clk,
	input  wire logic        filter_run,
	input  wire logic        chop_invert,
	input  wire logic        ext_on,
	input  wire logic [23:0] level,
	input  wire logic [23:0] drift,
	output logic [23:0]      raw_data,
	output logic             ext_clk
);
	// free phase against clk, stands low while switched off
	initial begin
		ext_clk = 1'b0;
		#13;
		forever #200 ext_clk = ext_on ? ~ext_clk : 1'b0;
	end

	// drift stays put while the input is reversed; junk outside the filter phase
	always @(posedge clk) begin
		if (filter_run) begin
			raw_data <= chop_invert ? drift - level : drift + level;
		end else begin
			raw_data <= ~raw_data;
		end
	end
endmodule

// >>> test/acc_ctrl_test.sv
/*
 * Self-checking bench of the conversion control block: registers, calibration,
 * auto-zero, clock detection, result buffer and the three resets.
 * Assumes the short-count parameters and the byte register port of acc_ctrl.
 */
`timescale 1ns/100ps
module acc_ctrl_test;
	logic        clk;
	logic        rst_n;
	logic        reset_pin_n;
	logic        reset_cmd;
	logic        start_pin;
	logic        ext_clk;
	logic        ext_on;
	logic        reg_wr;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rd_data;
	logic [23:0] raw_data;
	logic [23:0] level;
	logic [23:0] drift;
	logic        sample_ready_n;
	logic        filter_run;
	logic        chop_invert;
	logic        clk_sel_ext;
	logic        out_valid;
	logic [23:0] out_data;
	logic        out_ready;
	int          fail_count;
	int          check_count;
	int          n;
	logic [7:0]  b;
	logic [23:0] tbl [7][3];

	acc_ctrl #(.POR_CYC(64), .FILT_CYC(20), .FIFO_D(32)) i_dut (
		.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .reset_cmd(reset_cmd),
		.start_pin(start_pin), .external_clock_input(ext_clk), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data),
		.raw_data(raw_data), .sample_ready_n(sample_ready_n), .filter_run(filter_run),
		.chop_invert(chop_invert), .clk_sel_ext(clk_sel_ext), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready)
	);

	acc_filter_model i_filter (
		.clk(clk), .filter_run(filter_run), .chop_invert(chop_invert), .ext_on(ext_on),
		.level(level), .drift(drift), .raw_data(raw_data), .ext_clk(ext_clk)
	);

	always #25 clk = ~clk;

	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		@(posedge clk);
		#1 b = reg_rd_data;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk({16'h0000, b}, {16'h0000, exp});
	endtask

	task automatic wr24(input logic [7:0] a, input logic [23:0] v);
		for (int i = 0; i < 3; i++) wr(a + 8'(i), v[8*i +: 8]);
	endtask

	function automatic logic [23:0] cal_exp(logic [23:0] raw, logic [23:0] ofs,
			logic [23:0] gain);
		longint d;
		d = longint'($signed(raw)) - longint'($signed(ofs));
		d = (d * longint'(gain)) >>> 22;
		if (d > 64'sh7FFFFF) d = 64'sh7FFFFF;
		if (d < -64'sh800000) d = -64'sh800000;
		return d[23:0];
	endfunction

	task automatic drain();
		@(posedge clk);
		out_ready <= 1'b1;
		repeat (150) @(posedge clk);
		out_ready <= 1'b0;
	endtask

	// first result after start is taken and compared, the rest flushed
	task automatic conv(input logic [23:0] lv, input logic [23:0] exp);
		logic [23:0] d;
		@(posedge clk);
		level     <= lv;
		start_pin <= 1'b1;
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk);
			#1;
			if (out_valid === 1'b1) break;
		end
		d = out_data;
		@(posedge clk);
		out_ready <= 1'b1;
		start_pin <= 1'b0;
		@(posedge clk);
		out_ready <= 1'b0;
		chk(d, exp);
		drain();
	endtask

	// cycles from here to filter start, ignoring the first eight
	task automatic time_start();
		n = 0;
		while ((n < 8 || filter_run !== 1'b1) && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("FAIL at %0t: got %h expected %h", $time, 0, 1);
		test_done();
	end

	initial begin
		clk = 1'b0; rst_n = 1'b0; reset_pin_n = 1'b1; reset_cmd = 1'b0;
		start_pin = 1'b0; ext_on = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00;
		reg_wdata = 8'h00; level = 24'h000000; drift = 24'h000000; out_ready = 1'b0;
		fail_count = 0; check_count = 0;
		tbl = '{'{24'h100000, 24'h000000, 24'h400000}, '{24'h100000, 24'h000100, 24'h400000},
			'{24'h100000, 24'h000000, 24'h800000}, '{24'h600000, 24'h000000, 24'h800000},
			'{24'hA00000, 24'h000000, 24'h800000}, '{24'h000000, 24'h000001, 24'h400000},
			'{24'h100000, 24'hFFFFFF, 24'h3CCCCC}};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		n = 0;
		@(posedge clk);
		#1;
		while (sample_ready_n === 1'b0 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(24'(n >= 60 && n <= 68), 24'h000001);
		for (int j = 0; j < 3; j++) rchk(acc_pkg::ADDR_OFS0 + 8'(j), 8'h00);
		for (int j = 0; j < 3; j++) rchk(acc_pkg::ADDR_GAIN0 + 8'(j), acc_pkg::GAIN_RST[8*j +: 8]);
		rchk(acc_pkg::ADDR_CONFIG, acc_pkg::CONFIG_RST);
		rd(acc_pkg::ADDR_STATE);
		chk(24'(b[acc_pkg::ST_FLAG_BIT]), 24'h000001);
		wr(acc_pkg::ADDR_STATE, 8'h01);
		rd(acc_pkg::ADDR_STATE);
		chk(24'(b[acc_pkg::ST_FLAG_BIT]), 24'h000000);
		wr(8'h05, 8'hA5);
		rchk(8'h05, 8'h00);
		wr(acc_pkg::ADDR_CONFIG, 8'h02);
		for (int i = 0; i < 7; i++) begin
			wr24(acc_pkg::ADDR_OFS0, tbl[i][1]);
			wr24(acc_pkg::ADDR_GAIN0, tbl[i][2]);
			for (int j = 0; j < 3; j++) rchk(acc_pkg::ADDR_OFS0 + 8'(j), tbl[i][1][8*j +: 8]);
			for (int j = 0; j < 3; j++) rchk(acc_pkg::ADDR_GAIN0 + 8'(j), tbl[i][2][8*j +: 8]);
			conv(tbl[i][0], cal_exp(tbl[i][0], tbl[i][1], tbl[i][2]));
		end
		wr24(acc_pkg::ADDR_OFS0, 24'h000000);
		wr24(acc_pkg::ADDR_GAIN0, 24'h400000);
		drift <= 24'h001234;
		wr(acc_pkg::ADDR_CONFIG, 8'h03);
		conv(24'h050000, 24'h050000);
		wr(acc_pkg::ADDR_CONFIG, 8'h01);
		conv(24'h050000, 24'h051234);
		ext_on <= 1'b1;
		repeat (100) @(posedge clk);
		rd(acc_pkg::ADDR_STATE);
		chk(24'(b[acc_pkg::ST_CLK_BIT]), 24'h000001);
		chk(24'(clk_sel_ext), 24'h000001);
		ext_on <= 1'b0;
		repeat (150) @(posedge clk);
		rd(acc_pkg::ADDR_STATE);
		chk(24'(b[acc_pkg::ST_CLK_BIT]), 24'h000000);
		chk(24'(clk_sel_ext), 24'h000000);
		// buffer filled with the consumer stalled, then emptied
		drift <= 24'h000000;
		wr(acc_pkg::ADDR_CONFIG, 8'h02);
		@(posedge clk);
		level     <= 24'h010000;
		start_pin <= 1'b1;
		repeat (1200) @(posedge clk);
		start_pin <= 1'b0;
		out_ready <= 1'b1;
		n = 0;
		for (int k = 0; k < 400; k++) begin
			@(posedge clk);
			#1;
			if (out_valid === 1'b1) begin
				n++;
				chk(out_data, 24'h010000);
			end
		end
		@(posedge clk);
		out_ready <= 1'b0;
		chk(24'(n >= 32), 24'h000001);
		chk(24'(sample_ready_n), 24'h000000);
		// start held high across each reset
		wr24(acc_pkg::ADDR_OFS0, 24'h123456);
		@(posedge clk);
		reset_cmd <= 1'b1;
		start_pin <= 1'b1;
		@(posedge clk);
		reset_cmd <= 1'b0;
		time_start();
		chk(24'(n >= 1505 && n <= 1530), 24'h000001);
		chk(24'(sample_ready_n), 24'h000001);
		rchk(acc_pkg::ADDR_OFS2, 8'h00);
		rchk(acc_pkg::ADDR_CONFIG, acc_pkg::CONFIG_RST);
		rd(acc_pkg::ADDR_STATE);
		chk(24'(b[acc_pkg::ST_FLAG_BIT]), 24'h000001);
		wr(acc_pkg::ADDR_STATE, 8'h01);
		@(posedge clk);
		reset_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_pin_n <= 1'b1;
		time_start();
		chk(24'(n >= 1505 && n <= 1530), 24'h000001);
		rd(acc_pkg::ADDR_STATE);
		chk(24'(b[acc_pkg::ST_FLAG_BIT]), 24'h000001);
		test_done();
	end
endmodule
